// file: hw/stpf_bank.sv
/*
  Positive-transition filter bank: five 16-bit mask registers written and
  queried by an external command parser, and five filter channels.
  Assumes the parser converts decimal parameters to binary and back,
  and that all inputs are synchronous to clk_in.
*/
// Notes on behaviour
// - Five separate masks: operation, trigger, arm, sequence, questionable, each own command.
// - Decimal parameter maps bit weights to bits; zero clears all bits.
// - Power-up and preset set all mask bits; clear-status leaves masks alone.
// - Query returns mask contents whose binary form shows the set bits.
// - A rise is a condition bit going 0 to 1 between evaluations.
// - Enabled mask bit plus rising condition bit sets the event bit at a defined event position.
// - Operation bit B1 enables settling start event on event bit B1.
// - Operation B6 enables arm-wait, B5 trigger-wait; 96 enables both.
// - Operation mask enables idle entry event on event bit B10.
// - Questionable mask enables too-many-channels event on event bit B9.
`timescale 1ns/10ps
module stpf_bank #(
  parameter int unsigned W = stpf_pkg::REG_W
) (
  input  wire logic                                  clk_in,
  input  wire logic                                  sys_rst_in,
  input  wire logic                                  wr_in,
  input  wire logic                                  rd_in,
  input  wire logic [stpf_pkg::SEL_W-1:0]            sel_in,
  input  wire logic [W-1:0]                          wdata_in,
  input  wire logic                                  preset_in,
  input  wire logic                                  clr_status_in,
  input  wire logic [stpf_pkg::SRC_NUM*W-1:0]        cond_in,
  input  wire logic [stpf_pkg::SRC_NUM-1:0]          ev_clr_in,
  output logic      [W-1:0]                          rdata_out,
  output logic                                       rvalid_out,
  output logic      [stpf_pkg::SRC_NUM*W-1:0]        mask_out,
  output logic      [stpf_pkg::SRC_NUM*W-1:0]        event_out
);

  // ----------------------------------------------------------------------
  // Defined event positions per register
  // ----------------------------------------------------------------------
  localparam logic [W-1:0] DEF_OPER = W'((1 << stpf_pkg::BIT_SETTLE)
                                       | (1 << stpf_pkg::BIT_TRIG_W)
                                       | (1 << stpf_pkg::BIT_ARM_W)
                                       | (1 << stpf_pkg::BIT_IDLE));
  localparam logic [W-1:0] DEF_TRIG = W'(1 << stpf_pkg::BIT_SEQ1);
  localparam logic [W-1:0] DEF_ARM  = W'(1 << stpf_pkg::BIT_SEQ1);
  localparam logic [W-1:0] DEF_SEQ  = W'((1 << stpf_pkg::BIT_LAYER1) | (1 << stpf_pkg::BIT_LAYER2));
  localparam logic [W-1:0] DEF_QUES = W'(1 << stpf_pkg::BIT_CHAN);
  localparam logic [stpf_pkg::SRC_NUM*W-1:0] DEF_ALL = {DEF_QUES, DEF_SEQ, DEF_ARM, DEF_TRIG, DEF_OPER};

  // Selection code is the channel index; codes past the last are unmapped
  function automatic logic sel_ok(input logic [stpf_pkg::SEL_W-1:0] s);
    sel_ok = (s <= stpf_pkg::SEL_QUES);
  endfunction

  logic [W-1:0] mask [stpf_pkg::SRC_NUM];
  logic [W-1:0] next_mask [stpf_pkg::SRC_NUM];
  logic [W-1:0] next_rdata;
  logic         next_rvalid;

  // ----------------------------------------------------------------------
  // Mask registers and query port
  // ----------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < stpf_pkg::SRC_NUM; i++) begin
      next_mask[i] = mask[i];
      // Clear-status is deliberately not looked at here
      if (preset_in) begin
        next_mask[i] = stpf_pkg::MASK_PRESET;
      end else if (wr_in && sel_ok(sel_in) && (sel_in == stpf_pkg::SEL_W'(i))) begin
        next_mask[i] = wdata_in;
      end
    end
    next_rvalid = rd_in;
    next_rdata  = stpf_pkg::ZERO_WORD;
    if (rd_in && sel_ok(sel_in)) begin
      next_rdata = mask[sel_in];
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < stpf_pkg::SRC_NUM; i++) begin
        mask[i] <= stpf_pkg::MASK_PRESET;
      end
      rdata_out  <= stpf_pkg::ZERO_WORD;
      rvalid_out <= 1'b0;
    end else begin
      for (int i = 0; i < stpf_pkg::SRC_NUM; i++) begin
        mask[i] <= next_mask[i];
      end
      rdata_out  <= next_rdata;
      rvalid_out <= next_rvalid;
    end
  end

  // ----------------------------------------------------------------------
  // Filter channels
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < stpf_pkg::SRC_NUM; g++) begin : g_chan
    assign mask_out[g*W +: W] = mask[g];
    stpf_chan #(
      .W       (W),
      .DEFINED (DEF_ALL[g*W +: W])
    ) u_chan (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .cond_in    (cond_in[g*W +: W]),
      .mask_in    (mask[g]),
      .clr_in     (ev_clr_in[g] | clr_status_in),
      .event_out  (event_out[g*W +: W])
    );
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence oper_write_s;
    wr_in && !preset_in && (sel_in == stpf_pkg::SEL_OPER);
  endsequence

  sequence oper_query_s;
    rd_in && (sel_in == stpf_pkg::SEL_OPER);
  endsequence

  preset_sets_all_a: assert property (preset_in |=> (mask_out == {stpf_pkg::SRC_NUM{stpf_pkg::MASK_PRESET}}))
    else $error("preset did not set every mask bit");
  clear_keeps_mask_a: assert property (clr_status_in && !preset_in && !wr_in |=> $stable(mask_out))
    else $error("clear-status changed a mask");
  oper_write_load_a: assert property (oper_write_s |=> (mask_out[W-1:0] == $past(wdata_in)))
    else $error("operation mask write not stored");
  other_masks_kept_a: assert property (oper_write_s |=> (mask_out[stpf_pkg::SRC_NUM*W-1:W]
                                                       == $past(mask_out[stpf_pkg::SRC_NUM*W-1:W])))
    else $error("write touched another mask");
  write_then_query_a: assert property (oper_write_s ##1 (oper_query_s and (!wr_in && !preset_in))
                                       |=> rvalid_out && (rdata_out == $past(wdata_in, 2)))
    else $error("query did not return written value");
  query_pulse_a: assert property (rd_in |=> rvalid_out && (rdata_out == $past(sel_ok(sel_in)
                                   ? mask_out[sel_in*W +: W] : stpf_pkg::ZERO_WORD)))
    else $error("query answer wrong");
  no_read_no_valid_a: assert property (!rd_in |=> !rvalid_out)
    else $error("answer without query");
  settle_event_a: assert property (g_chan[0].u_chan.armed && mask_out[stpf_pkg::BIT_SETTLE]
                                   && cond_in[stpf_pkg::BIT_SETTLE] && !$past(cond_in[stpf_pkg::BIT_SETTLE])
                                   |=> event_out[stpf_pkg::BIT_SETTLE])
    else $error("settling start did not set event");

endmodule // stpf_bank

// file: hw/stpf_pkg.sv
/*
  Constants shared by the positive-transition filter bank: register
  selection codes, widths, reset value and the defined event bit positions.
  Assumes a command parser that has already turned the decimal parameter
  into a 16-bit binary value.
*/
package stpf_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int unsigned REG_W   = 16;
  localparam int unsigned SRC_NUM = 5;
  localparam int unsigned SEL_W   = 3;

  // ----------------------------------------------------------------------
  // Register selection codes
  // ----------------------------------------------------------------------
  localparam logic [SEL_W-1:0] SEL_OPER = 3'h0;
  localparam logic [SEL_W-1:0] SEL_TRIG = 3'h1;
  localparam logic [SEL_W-1:0] SEL_ARM  = 3'h2;
  localparam logic [SEL_W-1:0] SEL_SEQ  = 3'h3;
  localparam logic [SEL_W-1:0] SEL_QUES = 3'h4;

  // ----------------------------------------------------------------------
  // Reset and bit positions
  // ----------------------------------------------------------------------
  localparam logic [REG_W-1:0] MASK_PRESET = 16'hffff;
  localparam logic [REG_W-1:0] ZERO_WORD   = 16'h0000;
  localparam int unsigned BIT_SETTLE   = 1;
  localparam int unsigned BIT_TRIG_W   = 5;
  localparam int unsigned BIT_ARM_W    = 6;
  localparam int unsigned BIT_CHAN     = 9;
  localparam int unsigned BIT_IDLE     = 10;
  localparam int unsigned BIT_SEQ1     = 1;
  localparam int unsigned BIT_LAYER1   = 1;
  localparam int unsigned BIT_LAYER2   = 2;

endpackage

// file: hw/stpf_chan.sv
/*
  One transition filter channel: remembers the last condition word, finds
  0-to-1 changes, gates them by the mask and holds the event register.
  Assumes condition inputs synchronous to clk_in.
*/
`timescale 1ns/10ps
module stpf_chan #(
  parameter int unsigned               W       = 16,
  parameter logic [W-1:0]              DEFINED = 16'hffff
) (
  input  wire logic         clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic [W-1:0] cond_in,
  input  wire logic [W-1:0] mask_in,
  input  wire logic         clr_in,
  output logic      [W-1:0] event_out
);

  logic [W-1:0] prev;
  logic [W-1:0] next_prev;
  logic         armed;
  logic         next_armed;
  logic [W-1:0] next_event;
  logic [W-1:0] set_bits;

  // ----------------------------------------------------------------------
  // Edge detection and event holding
  // ----------------------------------------------------------------------
  always_comb begin
    next_prev  = cond_in;
    next_armed = 1'b1;
    // No edges on the first cycle after reset: prev is not yet meaningful
    set_bits   = {W{armed}} & cond_in & ~prev & mask_in & DEFINED;
    // Set wins over clear so a rise in the clear cycle is kept
    next_event = (event_out & ~{W{clr_in}}) | set_bits;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      prev      <= '0;
      armed     <= 1'b0;
      event_out <= '0;
    end else begin
      prev      <= next_prev;
      armed     <= next_armed;
      event_out <= next_event;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence rise_s;
    armed && ((cond_in & ~prev & mask_in & DEFINED) != '0);
  endsequence

  rise_sets_event_a: assert property (rise_s |=> ((event_out & $past(cond_in & ~prev & mask_in & DEFINED))
                                                  == $past(cond_in & ~prev & mask_in & DEFINED)))
    else $error("masked rise did not set event bit");
  no_unmasked_set_a: assert property (1'b1 |=> ((event_out & ~$past(event_out)
                                                 & ~($past(cond_in & ~prev & mask_in) & DEFINED)) == '0))
    else $error("event bit set without enabled rise");
  undefined_bits_zero_a: assert property ((event_out & ~DEFINED) == '0)
    else $error("undefined event position set");
  event_hold_a: assert property (!clr_in |=> ((event_out & $past(event_out)) == $past(event_out)))
    else $error("event bit dropped without clear");

endmodule // stpf_chan

// file: tb/stpf_host.sv
/*
  Host command model: mask writes and queries as one-cycle strobes.
  Assumes the bank answers a query one cycle after the strobe.
*/
`timescale 1ns/10ps
module stpf_host (
  input  wire logic        clk_in,
  input  wire logic        rvalid_in,
  input  wire logic [15:0] rdata_in,
  output logic             wr_out = 1'b0,
  output logic             rd_out = 1'b0,
  output logic [2:0]       sel_out = 3'h7,
  output logic [15:0]      wdata_out = 16'h5a5a
);
  task write(input logic [2:0] s, input logic [15:0] v);
    @(posedge clk_in);
    #1;
    wr_out = 1'b1;
    sel_out = s;
    wdata_out = v; // Binary form of the sum of weights
    @(posedge clk_in);
    #1;
    wr_out = 1'b0;
    wdata_out = ~v; // Released data must not look valid
  endtask

  // Write and query with no idle cycle between them
  task write_query(input logic [2:0] s, input logic [15:0] v, output logic [15:0] d, output bit ok);
    @(posedge clk_in);
    #1;
    wr_out = 1'b1;
    sel_out = s;
    wdata_out = v;
    @(posedge clk_in);
    #1;
    wr_out = 1'b0;
    rd_out = 1'b1;
    wdata_out = ~v;
    @(posedge clk_in);
    #1;
    rd_out = 1'b0;
    ok = rvalid_in === 1'b1;
    d = rdata_in;
  endtask

  task query(input logic [2:0] s, output logic [15:0] d, output bit ok);
    @(posedge clk_in);
    #1;
    rd_out = 1'b1;
    sel_out = s;
    @(posedge clk_in);
    #1;
    rd_out = 1'b0;
    ok = rvalid_in === 1'b1;
    d = rdata_in;
  endtask
endmodule // stpf_host

// file: tb/stpf_bank_tb.sv
/*
  Bench for the filter bank: host model commands, random condition words
  and clears, and a reference model compared with every output each cycle.
  Assumes one 10 MHz clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module stpf_bank_tb;
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        wr, rd, rvalid, preset = 1'b0, clr_st = 1'b0, live = 1'b0, ok;
  logic [2:0]  sel;
  logic [4:0]  ev_clr = 5'h00;
  logic [15:0] wdata, rdata, d, m_rd;
  logic [79:0] cond = '0, mask, ev, m_mask, m_ev, m_prev, rise;
  logic        m_rv, m_first;
  logic [31:0] seed = 32'h8888f3ce;
  int          errors = 0, comparisons = 0;
  // Defined event positions per register, questionable at the top
  localparam logic [79:0] DEFD = {16'h0200, 16'h0006, 16'h0002, 16'h0002, 16'h0462};
  localparam int BITS [6] = '{1, 2, 5, 6, 9, 10};

  stpf_bank dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .wr_in(wr), .rd_in(rd), .sel_in(sel),
    .wdata_in(wdata), .preset_in(preset), .clr_status_in(clr_st), .cond_in(cond), .ev_clr_in(ev_clr),
    .rdata_out(rdata), .rvalid_out(rvalid), .mask_out(mask), .event_out(ev));
  stpf_host host (.clk_in(clk_in), .rvalid_in(rvalid), .rdata_in(rdata), .wr_out(wr), .rd_out(rd),
    .sel_out(sel), .wdata_out(wdata));

  initial begin
    forever #50 clk_in = ~clk_in;
  end

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task check(input logic [79:0] seen, input logic [79:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task q(input logic [2:0] s, input logic [15:0] exp);
    host.query(s, d, ok);
    check(80'({ok, d}), 80'({1'b1, exp}));
  endtask

  // --------------------------------------------------------------------
  // Reference model: set wins over clear, preset wins over write
  // --------------------------------------------------------------------
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      m_mask = {5{16'hffff}};
      m_ev = '0;
      m_rv = 1'b0;
      m_rd = 16'h0000;
      m_first = 1'b1;
    end else begin
      m_rv = rd;
      m_rd = (rd && sel < 3'h5) ? m_mask[sel*16 +: 16] : 16'h0000;
      rise = m_first ? '0 : cond & ~m_prev & m_mask & DEFD;
      for (int i = 0; i < 5; i++)
        if (ev_clr[i] || clr_st)
          m_ev[i*16 +: 16] = 16'h0000;
      m_ev |= rise;
      if (preset)
        m_mask = {5{16'hffff}};
      else if (wr && sel < 3'h5)
        m_mask[sel*16 +: 16] = wdata;
      m_first = 1'b0;
    end
    m_prev = cond;
  end

  always @(negedge clk_in) begin
    if (live) begin
      check(mask, m_mask);
      check(ev, m_ev);
      check(80'({rvalid, rdata}), 80'({m_rv, m_rd}));
    end
  end

  initial begin
    #3000000;
    errors++;
    print_verdict();
  end

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_in);
    #1;
    sys_rst_in = 1'b0;
    live = 1'b1;
    for (int r = 0; r < 5; r++) begin
      q(3'(r), 16'hffff);
      foreach (BITS[k]) begin
        host.write(3'(r), 16'h0001 << BITS[k]);
        q(3'(r), 16'h0001 << BITS[k]);
      end
      host.write(3'(r), 16'h0000);
      q(3'(r), 16'h0000);
    end
    host.write_query(3'h0, 16'h0060, d, ok);
    check(80'({ok, d}), 80'({1'b1, 16'h0060}));
    host.write(3'h6, 16'h1234);
    q(3'h6, 16'h0000);
    fork
      repeat (3000) begin
        @(posedge clk_in);
        #1;
        cond = 80'({rnd(), rnd(), rnd()});
        ev_clr = 5'(rnd() & rnd() & rnd());
        clr_st = (rnd() & 32'h3f) == 0;
        preset = (rnd() & 32'h7f) == 0;
      end
      repeat (400) begin
        host.write(3'(rnd() % 8), 16'(rnd()));
        host.query(3'(rnd() % 8), d, ok);
        host.write_query(3'(rnd() % 8), 16'(rnd()), d, ok);
      end
    join
    print_verdict();
  end
endmodule // stpf_bank_tb
